// ===== rtl/lpmkc_pkg.sv
package lpmkc_pkg;

  // ************************************************************
  // Register map (word offsets as byte addresses)
  // ************************************************************
  localparam logic [7:0] ADR_CTRL     = 8'h00;
  localparam logic [7:0] ADR_KEY_CTRL = 8'h04;
  localparam logic [7:0] ADR_KEY_RTC  = 8'h08;
  localparam logic [7:0] ADR_RTC_ALRM = 8'h0c;

  // ************************************************************
  // Control register field positions
  // ************************************************************
  localparam int POS_MODE     = 0;
  localparam int POS_CLOCK_SOURCE_SELECT     = 2;
  localparam int POS_TIMER_EVENT_STATUS    = 3;
  localparam int POS_TIMER_EXPIRED_STATUS    = 4;
  localparam int POS_CSR      = 5;
  localparam int POS_LOCK_LOSS_RESET_ENABLE    = 6;
  localparam int POS_FORCE_BUS_PULLDOWN    = 7;
  localparam int POS_LOW_GEAR_DIVIDER     = 8;
  localparam int POS_HIGH_GEAR_DIVIDER     = 12;
  localparam int POS_GEAR_HI  = 16;
  localparam int POS_KEY_OPEN = 0;

  // ************************************************************
  // Key mechanism and reset values
  // ************************************************************
  localparam logic [31:0] KEY_OPEN_VAL   = 32'h55ccaa33;
  localparam logic        KEY_CTRL_RST   = 1'b1;
  localparam logic        KEY_RTC_RST    = 1'b0;
  localparam logic [1:0]  MODE_NORMAL    = 2'h0;
  localparam logic [1:0]  MODE_DOZE      = 2'h1;
  localparam logic [1:0]  MODE_SLEEP     = 2'h2;
  localparam logic [1:0]  MODE_DEEP      = 2'h3;
  localparam logic        TIMER_EXPIRED_STATUS_RST      = 1'b1;
  localparam logic [2:0]  DIV_RST        = 3'h0;

  // ************************************************************
  // Wake-up timing
  // ************************************************************
  localparam int CLK_MHZ         = 100;
  localparam int ASYNC_WAKE_NS   = 30;
  localparam int ASYNC_WAKE_CYC  = (ASYNC_WAKE_NS * CLK_MHZ + 999) / 1000;
  localparam int DEEP_WAKE_REF   = 500;
  localparam int DEEP_WAKE_REF11 = 1000;

  typedef enum logic [1:0] {
    LPMKC_PM_NORMAL,
    LPMKC_PM_DOZE,
    LPMKC_PM_SLEEP,
    LPMKC_PM_DEEP
  } lpmkc_pm_t;

endpackage : lpmkc_pkg

// ===== rtl/lpmkc_core.sv
// Our own choices: the Wishbone slave port and the address map.
`timescale 1ns/1ns
// Notes on behaviour
// - Low-power mode writes accepted only in normal mode, ignored in doze.
// - Enabled asynchronous interrupt clears mode to normal, keeps clock source.
// - Async wake: controller wake request, or enabled timer-class events.
// - Async wake reaches normal high within three to four cycles.
// - Controller wake request is level sensitive, held until cause cleared.
// - Timer events set status; set status counts as pending async wake.
// - Synchronous interrupt reaches normal high two to four clocks later.
// - With clock source set, normal/doze toggle between low and high gear.
// - Normal low goes high on pending interrupt with power bit clear.
// - Without switch-up conditions, clear async status, return to low gear.
// - Doze exits to normal high on any pending controller interrupt.
// - Deep sleep keeps PLL off; wakes within 500 or 1000 input clocks.
// - Enabled timer-class event sets the timer-expired status.
// - Hard reset with expired bit and pin clear sets both.
// - Checkstop resets when enabled and debug off at reset; else ignored.
// - With debug enabled at reset, checkstop enters debug, no reset.
// - Lock loss asserts hard reset only when its enable is set.
// - Force pulldown in sleep or deep sleep zeroes address and data pins.
// - Expired pin follows status; software writing one negates it.
// - Per-register keys; magic value opens, other values lock; RTC starts locked.
// - Mode 00 normal, 01 doze, 10 sleep, 11 deep or power-down by status.
// - Expired status clears only on a software write of one.
// - Timer event status reset clear, set by timers, cleared by write one.
// - Clock source clear selects high divider, set selects low divider in low gear.
module lpmkc_core #(
  parameter int unsigned BUS_PINS = 32
) (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                por_i,
  // Wishbone classic slave
  input  wire logic                cyc_i,
  input  wire logic                stb_i,
  input  wire logic                we_i,
  input  wire logic [7:0]          adr_i,
  input  wire logic [3:0]          sel_i,
  input  wire logic [31:0]         dat_i,
  output      logic [31:0]         dat_o,
  output      logic                ack_o,
  // Wake, clock, reset and debug inputs
  input  wire logic                ic_wake_i,
  input  wire logic                ic_pend_i,
  input  wire logic                msr_power_mgmt_bit_i,
  input  wire logic                timer_evt_i,
  input  wire logic                timer_en_i,
  input  wire logic                ref_clk_en_i,
  input  wire logic                pll_1to1_i,
  input  wire logic                pll_lock_loss_i,
  input  wire logic                checkstop_i,
  input  wire logic                debug_strap_i,
  // Outputs
  output      logic                timer_expired_pin_o,
  output      logic                pll_enable_o,
  output      logic                gear_high_o,
  output      logic [2:0]          divider_o,
  output      logic [1:0]          power_mode_o,
  output      logic                clocks_run_o,
  output      logic                hard_reset_req_o,
  output      logic                debug_enter_o,
  output      logic                machine_check_o,
  output      logic                wake_timeout_o,
  output      logic [BUS_PINS-1:0] bus_pin_val_o,
  output      logic [BUS_PINS-1:0] bus_pin_oe_n_o
);

  if (BUS_PINS < 1 || BUS_PINS > 64) begin : g_pins_bad
    $error("BUS_PINS out of range");
  end

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  logic [4:0] sync1_r;
  logic [4:0] sync2_r;
  always_ff @(posedge clk_i) begin
    sync1_r <= {ic_wake_i, ic_pend_i, timer_evt_i, pll_lock_loss_i,
                checkstop_i};
    sync2_r <= sync1_r;
  end
  wire logic ic_wake_s  = sync2_r[4];
  wire logic ic_pend_s  = sync2_r[3];
  wire logic timer_s    = sync2_r[2];
  wire logic lockloss_s = sync2_r[1];
  wire logic chkstop_s  = sync2_r[0];

  logic timer_d_r;
  always_ff @(posedge clk_i) begin
    timer_d_r <= timer_s;
  end
  wire logic timer_evt = timer_s & ~timer_d_r & timer_en_i;

  // ************************************************************
  // Register state
  // ************************************************************
  logic [1:0] mode_r;
  logic       clock_source_select_r;
  logic       timer_event_status_r;
  logic       timer_expired_status_r;
  logic       csr_r;
  logic       lock_loss_reset_enable_r;
  logic       force_bus_pulldown_r;
  logic [2:0] low_gear_divider_r;
  logic [2:0] high_gear_divider_r;
  logic       gear_hi_r;
  logic       key_ctrl_r;
  logic       key_rtc_r;
  logic [31:0] rtc_alrm_r;
  logic       debug_r;
  logic       ack_r;
  logic       mchk_r;
  logic [31:0] dat_r;

  // ************************************************************
  // Bus decode
  // ************************************************************
  wire logic req      = cyc_i & stb_i & ~ack_r;
  wire logic wr       = req & we_i;
  wire logic hit_ctrl = adr_i == lpmkc_pkg::ADR_CTRL;
  wire logic hit_kc   = adr_i == lpmkc_pkg::ADR_KEY_CTRL;
  wire logic hit_kr   = adr_i == lpmkc_pkg::ADR_KEY_RTC;
  wire logic hit_alrm = adr_i == lpmkc_pkg::ADR_RTC_ALRM;
  wire logic wr_kc    = wr & hit_kc & (sel_i == 4'hf);
  wire logic wr_kr    = wr & hit_kr & (sel_i == 4'hf);
  wire logic wr_ctrl  = wr & hit_ctrl & key_ctrl_r & sel_i[0];
  wire logic wr_ctrl1 = wr & hit_ctrl & key_ctrl_r & sel_i[1];
  wire logic wr_alrm  = wr & hit_alrm & key_rtc_r;
  wire logic locked   = wr & ((hit_ctrl & ~key_ctrl_r)
                              | (hit_alrm & ~key_rtc_r));
  wire logic key_val  = dat_i == lpmkc_pkg::KEY_OPEN_VAL;

  // Low-power mode writes only land in normal mode
  wire logic mode_wr_ok = wr_ctrl & (mode_r == lpmkc_pkg::MODE_NORMAL);
  wire logic [1:0] mode_wd = dat_i[lpmkc_pkg::POS_MODE +: 2];

  // ************************************************************
  // Wake logic
  // ************************************************************
  // Timer status stays a pending wake until software clears it
  wire logic async_wake = ic_wake_s | timer_event_status_r;
  wire logic sync_wake  = ic_pend_s & ~msr_power_mgmt_bit_i;
  wire logic in_low     = mode_r == lpmkc_pkg::MODE_NORMAL ||
                          mode_r == lpmkc_pkg::MODE_DOZE;
  // Power-down (expired status clear) waits for hard reset instead
  wire logic deep_wait  = (mode_r == lpmkc_pkg::MODE_DEEP) & timer_expired_status_r;

  // Deep sleep restart counts reference ticks while PLL relocks
  logic [9:0] deep_cnt_r;
  logic       deep_wake_r;
  wire logic [9:0] deep_lim = pll_1to1_i ?
      10'(lpmkc_pkg::DEEP_WAKE_REF11) : 10'(lpmkc_pkg::DEEP_WAKE_REF);
  wire logic deep_done = deep_wake_r & ref_clk_en_i &
                         (deep_cnt_r == deep_lim - 10'h1);

  wire logic timer_event_status_clr = wr_ctrl & dat_i[lpmkc_pkg::POS_TIMER_EVENT_STATUS];
  wire logic timer_expired_status_clr = wr_ctrl & dat_i[lpmkc_pkg::POS_TIMER_EXPIRED_STATUS];
  wire logic clr_async = clock_source_select_r & ~async_wake & ~sync_wake &
                         ~gear_hi_r;

  // ************************************************************
  // Sequential state
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_r     <= lpmkc_pkg::MODE_NORMAL;
      clock_source_select_r     <= 1'b0;
      csr_r      <= 1'b0;
      lock_loss_reset_enable_r    <= 1'b0;
      force_bus_pulldown_r    <= 1'b0;
      low_gear_divider_r     <= lpmkc_pkg::DIV_RST;
      high_gear_divider_r     <= lpmkc_pkg::DIV_RST;
      gear_hi_r  <= 1'b1;
      deep_cnt_r <= 10'h0;
      deep_wake_r <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        clock_source_select_r  <= dat_i[lpmkc_pkg::POS_CLOCK_SOURCE_SELECT];
        csr_r   <= dat_i[lpmkc_pkg::POS_CSR];
        lock_loss_reset_enable_r <= dat_i[lpmkc_pkg::POS_LOCK_LOSS_RESET_ENABLE];
        force_bus_pulldown_r <= dat_i[lpmkc_pkg::POS_FORCE_BUS_PULLDOWN];
      end
      if (wr_ctrl1) begin
        low_gear_divider_r <= dat_i[lpmkc_pkg::POS_LOW_GEAR_DIVIDER +: 3];
        high_gear_divider_r <= dat_i[lpmkc_pkg::POS_HIGH_GEAR_DIVIDER +: 3];
      end
      // Async wake returns to normal, clock source untouched
      if (async_wake && mode_r != lpmkc_pkg::MODE_DEEP) begin
        mode_r    <= lpmkc_pkg::MODE_NORMAL;
        gear_hi_r <= 1'b1;
      end else if (mode_r == lpmkc_pkg::MODE_DOZE && ic_pend_s) begin
        mode_r    <= lpmkc_pkg::MODE_NORMAL;
        gear_hi_r <= 1'b1;
      end else if (deep_done) begin
        mode_r      <= lpmkc_pkg::MODE_NORMAL;
        gear_hi_r   <= 1'b1;
        deep_wake_r <= 1'b0;
      end else if (mode_wr_ok) begin
        mode_r <= mode_wd;
      end else if (in_low && clock_source_select_r) begin
        gear_hi_r <= sync_wake;
      end else if (!clock_source_select_r) begin
        gear_hi_r <= 1'b1;
      end
      // Arm once only, so the clear on completion is not overridden
      if (deep_wait && !deep_wake_r && (ic_wake_s || timer_evt)) begin
        deep_wake_r <= 1'b1;
      end
      if (!deep_wake_r) begin
        deep_cnt_r <= 10'h0;
      end else if (ref_clk_en_i) begin
        deep_cnt_r <= deep_cnt_r + 10'h1;
      end
    end
  end

  // Status bits: hardware set wins over software clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_event_status_r <= 1'b0;
    end else if (timer_evt) begin
      timer_event_status_r <= 1'b1;
    end else if (timer_event_status_clr || clr_async) begin
      timer_event_status_r <= 1'b0;
    end
  end

  // Timer-expired bit survives hard reset by being set, not cleared
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_expired_status_r <= lpmkc_pkg::TIMER_EXPIRED_STATUS_RST;
    end else if (timer_evt) begin
      timer_expired_status_r <= 1'b1;
    end else if (timer_expired_status_clr) begin
      timer_expired_status_r <= 1'b0;
    end
  end

  // Keys live on the keep-alive rail: only power-on resets them
  always_ff @(posedge clk_i) begin
    if (por_i) begin
      key_ctrl_r <= lpmkc_pkg::KEY_CTRL_RST;
      key_rtc_r  <= lpmkc_pkg::KEY_RTC_RST;
      rtc_alrm_r <= 32'h0;
    end else begin
      if (wr_kc) begin
        key_ctrl_r <= key_val;
      end
      if (wr_kr) begin
        key_rtc_r <= key_val;
      end
      if (wr_alrm) begin
        rtc_alrm_r <= dat_i;
      end
    end
  end

  // Debug strap captured by clock at reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      debug_r <= debug_strap_i;
    end
  end

  // ************************************************************
  // Bus answer: one registered ack per request, a clock after the strobe
  // ************************************************************
  wire logic [31:0] ctrl_rd = {15'h0, gear_hi_r, 1'b0, high_gear_divider_r, 1'b0, low_gear_divider_r,
                               force_bus_pulldown_r, lock_loss_reset_enable_r, csr_r, timer_expired_status_r, timer_event_status_r,
                               clock_source_select_r, mode_r};
  wire logic [31:0] rd_mux =
      hit_ctrl ? ctrl_rd :
      hit_kc   ? {31'h0, key_ctrl_r} :
      hit_kr   ? {31'h0, key_rtc_r} :
      hit_alrm ? rtc_alrm_r : 32'h0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r  <= 1'b0;
      mchk_r <= 1'b0;
      dat_r  <= 32'h0;
    end else begin
      ack_r  <= req;
      mchk_r <= locked;
      if (req && !we_i) begin
        dat_r <= rd_mux;
      end
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  wire logic sleepish = mode_r == lpmkc_pkg::MODE_SLEEP ||
                        (mode_r == lpmkc_pkg::MODE_DEEP && timer_expired_status_r);
  wire logic pdrive   = force_bus_pulldown_r & sleepish;

  assign dat_o               = dat_r;
  assign ack_o               = ack_r;
  assign machine_check_o     = mchk_r;
  assign timer_expired_pin_o = timer_expired_status_r;
  assign power_mode_o        = mode_r;
  assign pll_enable_o        = mode_r != lpmkc_pkg::MODE_DEEP;
  assign clocks_run_o        = in_low;
  assign gear_high_o         = gear_hi_r | ~clock_source_select_r;
  assign divider_o           = gear_high_o ? high_gear_divider_r : low_gear_divider_r;
  assign hard_reset_req_o    = (chkstop_s & csr_r & ~debug_r)
                             | (lockloss_s & lock_loss_reset_enable_r);
  assign debug_enter_o       = chkstop_s & debug_r;
  assign wake_timeout_o      = deep_wake_r;
  assign bus_pin_val_o       = '0;
  assign bus_pin_oe_n_o      = {BUS_PINS{~pdrive}};

  // ************************************************************
  // Checks
  // ************************************************************
  a_doze_write_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
    (mode_r == lpmkc_pkg::MODE_DOZE && wr && hit_ctrl && !async_wake
     && !ic_pend_s) |=> mode_r == lpmkc_pkg::MODE_DOZE)
    else $error("mode changed by write in doze");
  // A software write in the same cycle may still set the clock source
  wire logic clock_source_select_wd = dat_i[lpmkc_pkg::POS_CLOCK_SOURCE_SELECT];
  a_async_wake_normal: assert property (@(posedge clk_i) disable iff (rst_i)
    (async_wake && mode_r != lpmkc_pkg::MODE_DEEP) |=>
      mode_r == lpmkc_pkg::MODE_NORMAL &&
      clock_source_select_r == ($past(wr_ctrl) ? $past(clock_source_select_wd) : $past(clock_source_select_r)))
    else $error("async wake did not restore normal");
  a_wake_latency: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(ic_wake_s) && mode_r == lpmkc_pkg::MODE_SLEEP |->
      ##[1:2] mode_r == lpmkc_pkg::MODE_NORMAL)
    else $error("async wake too slow");
  a_timer_event_status_set_wins: assert property (@(posedge clk_i) disable iff (rst_i)
    timer_evt |=> timer_event_status_r && timer_expired_status_r)
    else $error("timer event lost");
  a_timer_expired_status_zero_write: assert property (@(posedge clk_i) disable iff (rst_i)
    timer_expired_status_r && !timer_expired_status_clr |=> timer_expired_status_r)
    else $error("expired status cleared without write of one");
  a_lock_discards: assert property (@(posedge clk_i) disable iff (rst_i)
    locked && hit_alrm |=> $stable(rtc_alrm_r) && mchk_r)
    else $error("locked write not discarded");
  a_pulldown_mode: assert property (@(posedge clk_i) disable iff (rst_i)
    bus_pin_oe_n_o == '0 |-> force_bus_pulldown_r && mode_r[1])
    else $error("pulldown outside sleep");
  a_lock_loss_reset_enable_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    !lock_loss_reset_enable_r && !chkstop_s |-> !hard_reset_req_o)
    else $error("reset without enable");
  a_pin_tracks: assert property (@(posedge clk_i) disable iff (rst_i)
    timer_expired_status_clr && !timer_evt |=> !timer_expired_pin_o)
    else $error("pin not negated");

endmodule : lpmkc_core

// ===== bench/lpmkc_ext_model.sv
`timescale 1ns/1ns
// ********
// External supply switch and hard-reset logic
// ********
module lpmkc_ext_model #(
  parameter int HOLD = 6
) (
  input  wire logic       clk_i,
  input  wire logic       pin_i,
  input  wire logic [1:0] mode_i,
  output      logic       rst_o
);
  // Only a power-down (mode 11, pin low) arms the model
  logic       armed_r;
  logic [3:0] cnt_r;
  initial begin
    armed_r = 1'b0;
    cnt_r   = 4'h0;
  end
  assign rst_o = (cnt_r != 4'h0);
  always @(posedge clk_i) begin
    armed_r <= (mode_i == 2'h3) && !pin_i && !rst_o;
    if (armed_r && pin_i) begin
      cnt_r <= 4'(HOLD);
    end else if (cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
    end
  end
endmodule : lpmkc_ext_model

// ===== bench/lpmkc_core_tb.sv
`timescale 1ns/1ns
module lpmkc_core_tb;
  localparam logic [7:0] A_CTL = lpmkc_pkg::ADR_CTRL;
  localparam logic [7:0] A_KC  = lpmkc_pkg::ADR_KEY_CTRL;
  localparam logic [7:0] A_KR  = lpmkc_pkg::ADR_KEY_RTC;
  localparam logic [7:0] A_AL  = lpmkc_pkg::ADR_RTC_ALRM;
  localparam int         P_GEAR = 4;
  localparam int         P_RUN  = 3;
  localparam int         P_XRST = 2;
  localparam int         P_HRST = 1;
  localparam int         P_DBG  = 0;
  logic        clk, tb_rst, por, cyc, stb, we, ic_wake, ic_pend, msr_pow;
  logic        t_evt, t_en, ref_en, lock_loss, chkstop, strap, ack, pin;
  logic        pll_en, gear_hi, run, hrst, dbg, mchk, wto, ext_rst, mc, pll11;
  logic [1:0]  mode, ref_cnt;
  logic [2:0]  div;
  logic [7:0]  adr;
  logic [31:0] dat_w, dat_r, q, pval, poe_n;
  int          fail_count, total_checks, n, k;
  wire logic   rst = tb_rst | ext_rst;
  // Outputs that the bench waits on, picked by index
  wire logic [4:0] probe = {gear_hi, run, ext_rst, hrst, dbg};

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    ref_cnt <= ref_cnt + 2'h1;
    ref_en  <= (ref_cnt == 2'h3);
  end

  lpmkc_core u_dut (
    .clk_i(clk), .rst_i(rst), .por_i(por), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(dat_w), .dat_o(dat_r),
    .ack_o(ack), .ic_wake_i(ic_wake), .ic_pend_i(ic_pend),
    .msr_power_mgmt_bit_i(msr_pow), .timer_evt_i(t_evt), .timer_en_i(t_en),
    .ref_clk_en_i(ref_en), .pll_1to1_i(pll11), .pll_lock_loss_i(lock_loss),
    .checkstop_i(chkstop), .debug_strap_i(strap), .timer_expired_pin_o(pin),
    .pll_enable_o(pll_en), .gear_high_o(gear_hi), .divider_o(div),
    .power_mode_o(mode), .clocks_run_o(run), .hard_reset_req_o(hrst),
    .debug_enter_o(dbg), .machine_check_o(mchk), .wake_timeout_o(wto),
    .bus_pin_val_o(pval), .bus_pin_oe_n_o(poe_n)
  );
  lpmkc_ext_model #(.HOLD(6)) u_ext (
    .clk_i(clk), .pin_i(pin), .mode_i(mode), .rst_o(ext_rst)
  );

  task automatic stop_test();
    if (fail_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Holds the request until ack is sampled; no latency is assumed
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    {cyc, stb, we, adr, dat_w} <= {1'b1, 1'b1, w, a, d};
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (ack !== 1'b1 && i < 20);
    q = dat_r;
    mc = mchk;
    {cyc, stb} <= 2'b00;
    if (ack !== 1'b1) begin
      fail_count++;
      stop_test();
    end
  endtask : wb

  task automatic wait_bit(input int b, input logic v, input int lim,
                          input string nm);
    n = 0;
    while (probe[b] !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk(nm, {31'h0, v}, {31'h0, probe[b]});
  endtask : wait_bit

  task automatic do_reset(input logic p, input logic s);
    @(posedge clk);
    {tb_rst, por, strap} <= {1'b1, p, s};
    repeat (4) @(posedge clk);
    {tb_rst, por} <= 2'b00;
  endtask : do_reset

  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    stop_test();
  end

  initial begin
    {tb_rst, por, cyc, stb, we, ic_wake, ic_pend, msr_pow} = 8'hc0;
    {t_evt, t_en, lock_loss, chkstop, strap, ref_cnt, ref_en, pll11} = '0;
    {adr, dat_w, fail_count, total_checks} = '0;
    do_reset(1'b1, 1'b0);
    // ********
    // Reset state and keys
    // ********
    wb(0, A_CTL, 0); chk("ctrl", 32'h00010010, q);
    chk("pin", 1, pin);
    wb(0, A_KC, 0); chk("key_ctrl", 1, q);
    wb(0, A_KR, 0); chk("key_rtc", 0, q);
    wb(0, 8'h10, 0); chk("unmapped", 0, q);
    wb(1, A_AL, 32'h12345678); chk("mchk", 1, mc);
    wb(1, A_KR, lpmkc_pkg::KEY_OPEN_VAL);
    wb(1, A_AL, 32'h12345678); chk("mchk", 0, mc);
    wb(1, A_KR, 32'h55ccaa32); wb(1, A_AL, 0); chk("mchk", 1, mc);
    wb(0, A_AL, 0); chk("alarm", 32'h12345678, q);
    wb(1, A_KC, 0); wb(1, A_CTL, 32'h80); chk("mchk", 1, mc);
    wb(1, A_KC, lpmkc_pkg::KEY_OPEN_VAL); wb(0, A_CTL, 0);
    chk("ctrl", 32'h00010010, q);
    wb(1, A_CTL, 0); wb(0, A_CTL, 0); chk("ctrl", 32'h00010010, q);
    wb(1, A_CTL, 32'h10); wb(0, A_CTL, 0); chk("ctrl", 32'h10000, q);
    chk("pin", 0, pin);
    // ********
    // Gears, doze and sleep
    // ********
    wb(1, A_CTL, 32'h2500); chk("div", 2, div);
    wb(1, A_CTL, 32'h2504); wait_bit(P_GEAR, 0, 8, "gear");
    chk("div", 5, div);
    ic_pend <= 1'b1; wait_bit(P_GEAR, 1, 8, "gear");
    chk("div", 2, div);
    ic_pend <= 1'b0; wait_bit(P_GEAR, 0, 8, "gear");
    {ic_pend, msr_pow} <= 2'b11; repeat (6) @(posedge clk);
    chk("gear", 0, gear_hi);
    {ic_pend, msr_pow} <= 2'b00;
    wb(1, A_CTL, 32'h2505); chk("mode", 1, mode);
    wb(1, A_CTL, 32'h2506); chk("mode", 1, mode);
    ic_pend <= 1'b1; wait_bit(P_GEAR, 1, 6, "gear");
    chk("mode", 0, mode);
    ic_pend <= 1'b0;
    wb(1, A_CTL, 32'h86); chk("mode", 2, mode);
    chk("oe_n", 0, poe_n); chk("val", 0, pval);
    @(posedge clk); ic_wake <= 1'b1; k = 0;
    while (mode !== 2'h0 && k < 4) begin
      @(posedge clk);
      k++;
    end
    chk("mode", 0, mode);
    chk("oe_n", 32'hffffffff, poe_n);
    ic_wake <= 1'b0; wb(0, A_CTL, 0); chk("clock_source_select", 1, q[2]);
    // ********
    // Timer status, power-down, deep sleep
    // ********
    t_evt <= 1'b1; repeat (5) @(posedge clk);
    wb(0, A_CTL, 0); chk("status", 0, q[4:3]);
    {t_evt, t_en} <= 2'b01; repeat (2) @(posedge clk);
    t_evt <= 1'b1; repeat (5) @(posedge clk);
    wb(0, A_CTL, 0); chk("status", 3, q[4:3]);
    chk("pin", 1, pin);
    wb(1, A_CTL, 32'h01); wait_bit(P_RUN, 1, 6, "run");
    chk("mode", 0, mode);
    t_evt <= 1'b0; wb(1, A_CTL, 32'h18); wb(0, A_CTL, 0);
    chk("status", 0, q[4:3]);
    wb(1, A_CTL, 32'h03); repeat (2) @(posedge clk);
    chk("pll_en", 0, pll_en);
    t_evt <= 1'b1; wait_bit(P_XRST, 1, 12, "ext_rst");
    {t_evt, t_en} <= 2'b00; wait_bit(P_XRST, 0, 12, "ext_rst");
    wb(0, A_CTL, 0); chk("ctrl", 32'h00010010, q);
    wb(1, A_CTL, 32'h10); do_reset(1'b0, 1'b0);
    repeat (2) @(posedge clk);
    chk("pin", 1, pin);
    wb(0, A_AL, 0); chk("alarm", 32'h12345678, q);
    // Reference stays the slow oscillator stand-in here
    // Second pass runs the one-to-one mode with its longer restart
    for (int m = 0; m < 2; m++) begin
      pll11 <= m[0];
      repeat (3) @(posedge clk);
      wb(1, A_CTL, 32'h03);
      repeat (2) @(posedge clk);
      chk("pll_en", 0, pll_en);
      ic_wake <= 1'b1;
      k = 0;
      n = 0;
      while (mode !== 2'h0 && n < 4200) begin
        @(posedge clk);
        n++;
        if (ref_en === 1'b1) k++;
        if (n == 8) chk("wto", 1, wto);
      end
      chk("mode", 0, mode);
      chk("ref_ok", 1, k <= (m ? 1001 : 501));
      ic_wake <= 1'b0;
      repeat (2) @(posedge clk);
      chk("wto", 0, wto);
      chk("pll_en", 1, pll_en);
    end
    pll11 <= 1'b0;
    // ********
    // Reset sources
    // ********
    lock_loss <= 1'b1; repeat (6) @(posedge clk);
    chk("hrst", 0, hrst);
    wb(1, A_CTL, 32'h40); wait_bit(P_HRST, 1, 6, "hrst");
    lock_loss <= 1'b0; chkstop <= 1'b1; wb(1, A_CTL, 0);
    repeat (6) @(posedge clk);
    chk("hrst", 0, hrst);
    wb(1, A_CTL, 32'h20); wait_bit(P_HRST, 1, 6, "hrst");
    chk("dbg", 0, dbg);
    chkstop <= 1'b0; do_reset(1'b0, 1'b1);
    wb(1, A_CTL, 32'h20); chkstop <= 1'b1;
    wait_bit(P_DBG, 1, 6, "dbg"); chk("hrst", 0, hrst);
    chkstop <= 1'b0;
    stop_test();
  end
endmodule : lpmkc_core_tb
